// *** core/sspc_top.sv ***
// Purpose: Sleep-state plane controls and deep-sleep warn/acknowledge handshake
// Assumes: Sleep state, idle and C10 come from same-clock logic
// Notes:   Acknowledge is a pin and is synchronised
module sspc_top (
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_in,
   input  wire sspc_pkg::sspc_sleep_t sleep_state_in,
   input  wire logic                 ctrl_idle_in,
   input  wire logic                 cpu_c10_in,
   input  wire logic                 deep_sleep_enable_in,
   input  wire logic                 deep_sleep_request_in,
   input  wire logic                 wake_event_in,
   input  wire logic                 suspend_acknowledge_n_in,
   output logic                      idle_light_load_n_out,
   output logic                      suspend_ram_power_n_out,
   output logic                      suspend_disk_power_n_out,
   output logic                      soft_off_power_n_out,
   output logic                      deep_sleep_indication_n_out,
   output logic                      suspend_warning_n_out,
   output logic                      wake_honoured_out
);

   // ----------------------------------------
   // Acknowledge pin synchroniser
   // ----------------------------------------
   logic ack_n;

   sspc_sync u_ack_sync (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .d_in        (suspend_acknowledge_n_in),
      .q_out       (ack_n)
   );

   // ----------------------------------------
   // Plane decode
   // ----------------------------------------
   sspc_pkg::sspc_planes_t next_planes;
   sspc_pkg::sspc_deep_t   state;
   sspc_pkg::sspc_deep_t   next_state;
   wire in_s3  = (sleep_state_in == sspc_pkg::SSPC_S3);
   wire in_s4  = (sleep_state_in == sspc_pkg::SSPC_S4);
   wire in_s5  = (sleep_state_in == sspc_pkg::SSPC_S5);
   wire in_s0  = !(in_s3 || in_s4 || in_s5);
   wire ack_ok = (ack_n == suspend_warning_n_out);

   assign next_planes.idle_light_load_n    = !(in_s0 && ctrl_idle_in && cpu_c10_in);
   assign next_planes.suspend_ram_power_n  = !(in_s3 || in_s4 || in_s5);
   assign next_planes.suspend_disk_power_n = !(in_s4 || in_s5);
   assign next_planes.soft_off_power_n     = !in_s5;

   // ----------------------------------------
   // Deep-sleep handshake
   // ----------------------------------------
   wire want_deep = deep_sleep_enable_in && deep_sleep_request_in && !in_s0;
   wire block_wake = !suspend_warning_n_out && ack_n;

   always_comb begin
      next_state = state;
      case (state)
         sspc_pkg::SSPC_RUN: begin
            if (want_deep) begin
               next_state = sspc_pkg::SSPC_WARN;
            end
         end
         sspc_pkg::SSPC_WARN: begin
            if (!want_deep || wake_event_in) begin
               next_state = sspc_pkg::SSPC_RESUME;
            end else if (ack_ok) begin
               next_state = sspc_pkg::SSPC_DEEP;
            end
         end
         sspc_pkg::SSPC_DEEP: begin
            if (!want_deep || wake_event_in) begin
               next_state = sspc_pkg::SSPC_RESUME;
            end
         end
         sspc_pkg::SSPC_RESUME: begin
            if (ack_ok) begin
               next_state = sspc_pkg::SSPC_RUN;
            end
         end
         default: next_state = sspc_pkg::SSPC_RUN;
      endcase
   end

   wire next_warn_n = !(next_state == sspc_pkg::SSPC_WARN ||
                        next_state == sspc_pkg::SSPC_DEEP);
   wire next_deep_n = (next_state != sspc_pkg::SSPC_DEEP);
   wire next_wake   = wake_event_in && !block_wake &&
                      (state != sspc_pkg::SSPC_RUN || !in_s0);

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state                       <= sspc_pkg::SSPC_RUN;
         idle_light_load_n_out       <= sspc_pkg::SSPC_PLANES_RST.idle_light_load_n;
         suspend_ram_power_n_out     <= sspc_pkg::SSPC_PLANES_RST.suspend_ram_power_n;
         suspend_disk_power_n_out    <= sspc_pkg::SSPC_PLANES_RST.suspend_disk_power_n;
         soft_off_power_n_out        <= sspc_pkg::SSPC_PLANES_RST.soft_off_power_n;
         deep_sleep_indication_n_out <= sspc_pkg::SSPC_DEASSERT;
         suspend_warning_n_out       <= sspc_pkg::SSPC_DEASSERT;
         wake_honoured_out           <= 1'b0;
      end else begin
         state                       <= next_state;
         idle_light_load_n_out       <= next_planes.idle_light_load_n;
         suspend_ram_power_n_out     <= next_planes.suspend_ram_power_n;
         suspend_disk_power_n_out    <= next_planes.suspend_disk_power_n;
         soft_off_power_n_out        <= next_planes.soft_off_power_n;
         deep_sleep_indication_n_out <= next_deep_n;
         suspend_warning_n_out       <= next_warn_n;
         wake_honoured_out           <= next_wake;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_light_load;
      @(posedge core_clk_in) disable iff (rst_in)
      (in_s0 && ctrl_idle_in && cpu_c10_in) |=> !idle_light_load_n_out;
   endproperty
   a_light_load: assert property (p_light_load) else $error("light load not asserted");

   property p_ram;
      @(posedge core_clk_in) disable iff (rst_in)
      (in_s3 || in_s4 || in_s5) |=> !suspend_ram_power_n_out;
   endproperty
   a_ram: assert property (p_ram) else $error("ram plane not asserted");

   property p_disk;
      @(posedge core_clk_in) disable iff (rst_in)
      in_s3 |=> suspend_disk_power_n_out;
   endproperty
   a_disk: assert property (p_disk) else $error("disk plane asserted in S3");

   property p_soft;
      @(posedge core_clk_in) disable iff (rst_in)
      !soft_off_power_n_out |-> $past(in_s5);
   endproperty
   a_soft: assert property (p_soft) else $error("soft off outside S5");

   property p_deep_low;
      @(posedge core_clk_in) disable iff (rst_in)
      !deep_sleep_indication_n_out |-> !suspend_warning_n_out;
   endproperty
   a_deep_low: assert property (p_deep_low) else $error("deep sleep without warning");

   sequence s_leave_deep;
      !deep_sleep_indication_n_out ##1 (!want_deep || wake_event_in);
   endsequence
   property p_deep_exit;
      @(posedge core_clk_in) disable iff (rst_in)
      s_leave_deep |=> deep_sleep_indication_n_out;
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("deep sleep not left");

   property p_warn_first;
      @(posedge core_clk_in) disable iff (rst_in)
      $fell(deep_sleep_indication_n_out) |-> $past(!suspend_warning_n_out);
   endproperty
   a_warn_first: assert property (p_warn_first) else $error("warning not ahead of entry");

   property p_no_wake;
      @(posedge core_clk_in) disable iff (rst_in)
      block_wake |=> !wake_honoured_out;
   endproperty
   a_no_wake: assert property (p_no_wake) else $error("wake honoured without ack");

   property p_s0_idle;
      @(posedge core_clk_in) disable iff (rst_in)
      in_s0 |=> (suspend_ram_power_n_out && suspend_disk_power_n_out && soft_off_power_n_out);
   endproperty
   a_s0_idle: assert property (p_s0_idle) else $error("plane asserted in S0");

   // ----------------------------------------
   // Assertion of disk, soft-off, warning, deep-sleep and wake outputs; release of light load and warning
   // ----------------------------------------
   property p_light_off;
      @(posedge core_clk_in) disable iff (rst_in)
      !(in_s0 && ctrl_idle_in && cpu_c10_in) |=> idle_light_load_n_out;
   endproperty
   a_light_off: assert property (p_light_off) else $error("light load without idle");

   property p_disk_on;
      @(posedge core_clk_in) disable iff (rst_in)
      (in_s4 || in_s5) |=> !suspend_disk_power_n_out;
   endproperty
   a_disk_on: assert property (p_disk_on) else $error("disk plane not asserted");

   property p_soft_on;
      @(posedge core_clk_in) disable iff (rst_in)
      in_s5 |=> !soft_off_power_n_out;
   endproperty
   a_soft_on: assert property (p_soft_on) else $error("soft off not asserted");

   sequence s_deep_asked;
      (state == sspc_pkg::SSPC_RUN) && want_deep;
   endsequence
   property p_warn_entry;
      @(posedge core_clk_in) disable iff (rst_in)
      s_deep_asked |=> !suspend_warning_n_out;
   endproperty
   a_warn_entry: assert property (p_warn_entry) else $error("warning not raised");

   sequence s_ack_matched;
      (state == sspc_pkg::SSPC_WARN) && want_deep && !wake_event_in && ack_ok;
   endsequence
   property p_deep_entry;
      @(posedge core_clk_in) disable iff (rst_in)
      s_ack_matched |=> !deep_sleep_indication_n_out;
   endproperty
   a_deep_entry: assert property (p_deep_entry) else $error("deep sleep not entered");

   property p_warn_release;
      @(posedge core_clk_in) disable iff (rst_in)
      ((state == sspc_pkg::SSPC_DEEP) && (!want_deep || wake_event_in))
         |=> suspend_warning_n_out;
   endproperty
   a_warn_release: assert property (p_warn_release) else $error("warning not released");

   property p_wake_seen;
      @(posedge core_clk_in) disable iff (rst_in)
      (wake_event_in && !block_wake && !in_s0) |=> wake_honoured_out;
   endproperty
   a_wake_seen: assert property (p_wake_seen) else $error("wake not reported");

endmodule // sspc_top

// *** core/sspc_pkg.sv ***
// Purpose: Shared types and constants for the sleep-state power control block
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   All platform outputs except wake_honoured_out are active low
package sspc_pkg;

   // ----------------------------------------
   // Sleep states requested by the sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      SSPC_S0 = 3'h0,
      SSPC_S3 = 3'h3,
      SSPC_S4 = 3'h4,
      SSPC_S5 = 3'h5
   } sspc_sleep_t;

   // ----------------------------------------
   // Deep-sleep handshake states, one-hot
   // ----------------------------------------
   typedef enum logic [3:0] {
      SSPC_RUN    = 4'h1,
      SSPC_WARN   = 4'h2,
      SSPC_DEEP   = 4'h4,
      SSPC_RESUME = 4'h8
   } sspc_deep_t;

   // Active-low plane controls carried together
   typedef struct packed {
      logic idle_light_load_n;
      logic suspend_ram_power_n;
      logic suspend_disk_power_n;
      logic soft_off_power_n;
   } sspc_planes_t;

   localparam sspc_planes_t SSPC_PLANES_RST = 4'hf;
   localparam logic         SSPC_DEASSERT   = 1'b1;

endpackage

// *** core/sspc_sync.sv ***
// Purpose: Two-flop synchroniser for a pin level
// Assumes: Input is asynchronous to core_clk_in
// Notes:   First flop is read only by the second
module sspc_sync (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic d_in,
   output logic      q_out
);
   logic meta;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         meta  <= sspc_pkg::SSPC_DEASSERT;
         q_out <= sspc_pkg::SSPC_DEASSERT;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule // sspc_sync

// *** dv/sspc_partner_model.sv ***
// Purpose: Embedded controller that mirrors warning onto acknowledge
// Assumes: Delay is given in core clock cycles
// Notes:   Acknowledge idles high like a pulled-up pin
module sspc_partner_model (
   input  wire logic core_clk_in,
   input  wire logic suspend_warning_n_in,
   input  wire logic [31:0] delay_cyc_in,
   output logic      suspend_acknowledge_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial suspend_acknowledge_n_out = 1'b1;
   always @(posedge core_clk_in) begin
      if (suspend_acknowledge_n_out == suspend_warning_n_in) begin
         cnt <= 0;
      end else if (cnt >= delay_cyc_in) begin
         suspend_acknowledge_n_out <= suspend_warning_n_in;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // sspc_partner_model

// *** dv/test_sleep_state_power_control.sv ***
// Purpose: Self-checking bench for the sleep-state power control block
// Assumes: Inputs change on the falling clock edge
// Notes:   Partner model answers the deep-sleep warning
module test_sleep_state_power_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, idle = 0, c10 = 0, en = 0, req = 0, wake = 0;
   logic ack_n, ll_n, ram_n, disk_n, off_n, ind_n, warn_n, hon;
   sspc_pkg::sspc_sleep_t st = sspc_pkg::SSPC_S0;
   int delay_cyc = 2, error_cnt = 0, checked = 0;
   logic [2:0] codes [4] = '{3'h0, 3'h3, 3'h4, 3'h5};

   sspc_top i_dut (.core_clk_in(clk), .rst_in(rst), .sleep_state_in(st),
      .ctrl_idle_in(idle), .cpu_c10_in(c10), .deep_sleep_enable_in(en),
      .deep_sleep_request_in(req), .wake_event_in(wake),
      .suspend_acknowledge_n_in(ack_n), .idle_light_load_n_out(ll_n),
      .suspend_ram_power_n_out(ram_n), .suspend_disk_power_n_out(disk_n),
      .soft_off_power_n_out(off_n), .deep_sleep_indication_n_out(ind_n),
      .suspend_warning_n_out(warn_n), .wake_honoured_out(hon));
   sspc_partner_model i_ec (.core_clk_in(clk), .suspend_warning_n_in(warn_n),
      .delay_cyc_in(delay_cyc), .suspend_acknowledge_n_out(ack_n));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic check(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_for(ref logic sig, input logic lvl);
      for (int i = 0; i < 40 && sig !== lvl; i++) @(negedge clk);
   endtask

   task automatic print_verdict;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_planes;
      idle = 1;
      c10 = 1;
      foreach (codes[i]) begin
         st = sspc_pkg::sspc_sleep_t'(codes[i]);
         @(negedge clk);
         check(ram_n, codes[i] == 3'h0);
         check(disk_n, codes[i] < 3'h4);
         check(off_n, codes[i] != 3'h5);
         check(ll_n, codes[i] != 3'h0);
      end
      st = sspc_pkg::SSPC_S0;
      c10 = 0;
      @(negedge clk);
      check(ll_n, 1'b1);
      check(ram_n, 1'b1);
      idle = 0;
   endtask

   task automatic t_deep;
      st = sspc_pkg::SSPC_S3;
      req = 1;
      repeat (3) @(negedge clk);
      check(warn_n, 1'b1);
      en = 1;
      @(negedge clk);
      check(warn_n, 1'b0);
      check(ind_n, 1'b1);
      wait_for(ind_n, 1'b0);
      check(ind_n, 1'b0);
      check(ack_n, 1'b0);
      req = 0;
      @(negedge clk);
      check(ind_n, 1'b1);
      check(warn_n, 1'b1);
      wait_for(ack_n, 1'b1);
      repeat (4) @(negedge clk);
      req = 1;
      wait_for(ind_n, 1'b0);
      wake = 1;
      @(negedge clk);
      wake = 0;
      req = 0;
      check(hon, 1'b1);
      check(ind_n, 1'b1);
      wait_for(ack_n, 1'b1);
      repeat (4) @(negedge clk);
   endtask

   task automatic t_wake_blocked;
      delay_cyc = 12;
      req = 1;
      wait_for(warn_n, 1'b0);
      wake = 1;
      @(negedge clk);
      check(hon, 1'b0);
      check(warn_n, 1'b1);
      wake = 0;
      req = 0;
      repeat (20) @(negedge clk);
   endtask

   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      @(negedge clk);
      check(ll_n & ram_n & disk_n & off_n & ind_n & warn_n, 1'b1);
      check(hon, 1'b0);
      t_planes();
      t_deep();
      t_wake_blocked();
      print_verdict();
   end

   initial begin
      #(5000 * 50);
      error_cnt++;
      print_verdict();
   end
endmodule // test_sleep_state_power_control
